// ==== bench/lvimr_core_model.sv ====
`timescale 1ns/1ns
// Core side: takes fast before normal
module lvimr_core_model (
   input  wire logic       fast_req_in, // Fast request level
   input  wire logic       norm_req_in, // Normal request level
   output logic      [1:0] take_out     // 1 fast taken, 2 normal taken
);
   assign take_out = fast_req_in ? 2'h1 : {norm_req_in, 1'b0};
endmodule // lvimr_core_model

// ==== bench/lvimr_router_asserts.sv ====
`timescale 1ns/1ns
module lvimr_router_asserts
   import lvimr_pkg::*;
(
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic power_on_reset_n_in,
   input wire logic power_fail_reset_n_in,
   input wire logic user_reset_n_in,
   input wire lvimr_pkg::lvimr_fast_t fast_src_in,
   input wire lvimr_pkg::lvimr_norm_t norm_src_in,
   input wire logic mask_wr_in,
   input wire lvimr_pkg::lvimr_fast_t fast_mask_in,
   input wire lvimr_pkg::lvimr_norm_t norm_mask_in,
   input wire logic fast_interrupt_request_out,
   input wire logic normal_interrupt_request_out,
   input wire lvimr_pkg::lvimr_fast_t fast_status_out,
   input wire lvimr_pkg::lvimr_norm_t norm_status_out,
   input wire lvimr_pkg::lvimr_fast_t fast_mask_out,
   input wire lvimr_pkg::lvimr_norm_t norm_mask_out,
   input wire logic [1:0] cause_out
);
   wire logic ok = power_on_reset_n_in & power_fail_reset_n_in & user_reset_n_in; // No pin low
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   a_fast_any: assert property (fast_interrupt_request_out == |fast_status_out)
      else $error("fast request differs from status");
   a_norm_any: assert property (normal_interrupt_request_out == |norm_status_out)
      else $error("normal request differs from status");
   a_cause_prio: assert property (cause_out == {~fast_interrupt_request_out &
      normal_interrupt_request_out, fast_interrupt_request_out}) else $error("bad cause");
   a_mask_load: assert property (ok[*3] ##0 mask_wr_in ##1 (ok && !mask_wr_in)[*2] |->
      fast_mask_out == $past(fast_mask_in, 2) && norm_mask_out == $past(norm_mask_in, 2))
      else $error("mask write lost");
   a_pin_clear: assert property (!ok[*5] |-> fast_mask_out == 4'h0 && norm_mask_out == 24'h0)
      else $error("pin reset left mask");
   a_status_mask: assert property (($stable(fast_mask_out) && $stable(norm_mask_out))[*3] |->
      (fast_status_out & ~fast_mask_out) == 4'h0 && (norm_status_out & ~norm_mask_out) == 24'h0)
      else $error("masked source shown");
   a_zero_src: assert property ((fast_src_in == 4'h0 && norm_src_in == 24'h0)[*4] |->
      !fast_interrupt_request_out && !normal_interrupt_request_out) else $error("request held");
   a_follow_src: assert property ((fast_mask_out == 4'hF && $stable(fast_src_in))[*5] |->
      fast_status_out == fast_src_in) else $error("status not following source");
   c_both: cover property (fast_interrupt_request_out && normal_interrupt_request_out);
   c_norm_only: cover property (cause_out == 2'h2);
   c_pin: cover property (!ok[*5]);
endmodule // lvimr_router_asserts
bind lvimr_router lvimr_router_asserts u_lvimr_router_asserts (.*);

// ==== bench/lvimr_router_tb.sv ====
`timescale 1ns/1ns
module lvimr_router_tb;
   import lvimr_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, fq, nq; // Clock, reset, write, requests
   logic [2:0] pin = 3'h7;                            // Reset pins, all released
   logic [1:0] cz, tk;                                // Cause and core choice
   lvimr_fast_t fs = 4'h0, fm = 4'h0, fst, fmo;       // Fast sources, masks, views
   lvimr_norm_t ns = 24'h0, nm = 24'h0, nst, nmo;     // Normal sources, masks, views
   int n_errors = 0, comparisons = 0, cyc = 0;
   always #25 clk = ~clk;
   lvimr_router u_lvimr_router (.clock_in(clk), .rstn_in(rstn), .power_on_reset_n_in(pin[0]),
      .power_fail_reset_n_in(pin[1]), .user_reset_n_in(pin[2]), .fast_src_in(fs),
      .norm_src_in(ns), .mask_wr_in(wr), .fast_mask_in(fm), .norm_mask_in(nm),
      .fast_interrupt_request_out(fq), .normal_interrupt_request_out(nq), .fast_status_out(fst),
      .norm_status_out(nst), .fast_mask_out(fmo), .norm_mask_out(nmo), .cause_out(cz));
   lvimr_core_model u_lvimr_core_model (.fast_req_in(fq), .norm_req_in(nq), .take_out(tk));
   task final_report();
      $display("checks %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin n_errors++; final_report(); end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      if (got !== exp) begin $display("[ERR] %0t got %h want %h", $time, got, exp); n_errors++; end
      comparisons++;
   endtask
   task wait_n(input int n); repeat (n) @(negedge clk); endtask
   task wr_mask(input lvimr_fast_t f, input lvimr_norm_t n);
      @(negedge clk); wr = 1'b1; fm = f; nm = n;
      @(negedge clk); wr = 1'b0; wait_n(6);
   endtask
   task t_route();
      fs = 4'hA; ns = 24'h00F000; wait_n(6);
      chk(fq | nq, 0);
      wr_mask(4'h2, 24'h001000);
      chk(fmo, 4'h2);
      chk(fst, 4'h2); chk(nst, 24'h001000);
      chk(cz, 2'h1); chk(tk, 2'h1);
      fs = 4'h0; wait_n(6);
      chk(fq, 0); chk(tk, 2'h2);
      ns = 24'h0; wait_n(6);
      chk(cz, 2'h0);
      $display("t_route done");
   endtask
   task t_pins();
      for (int i = 0; i < 3; i++) begin
         wr_mask(4'hF, 24'hFFFFFF); fs = 4'h5; wait_n(6);
         chk(fst, 4'h5);
         pin[i] = 1'b0; wait_n(4);
         wr_mask(4'hF, 24'hFFFFFF);
         chk(fmo, 4'h0); chk(fq, 0);
         pin = 3'h7; wait_n(4);
         chk(fmo, 4'h0); chk(nmo, 24'h0);
      end
      $display("t_pins done");
   endtask
   initial begin
      wait_n(4); rstn = 1'b1;
      t_route(); t_pins(); final_report();
   end
endmodule // lvimr_router_tb

// ==== logic/lvimr_router.sv ====
`timescale 1ns/1ns
`include "lvimr_defs.svh"
module lvimr_router
   import lvimr_pkg::*;
(
   input  wire logic                clock_in,               // System clock, 20 MHz
   input  wire logic                rstn_in,                // Synchronous reset, active low
   input  wire logic                power_on_reset_n_in,    // Power-on reset pin, active low
   input  wire logic                power_fail_reset_n_in,  // Power-fail reset pin, active low
   input  wire logic                user_reset_n_in,        // User reset pin, active low
   input  wire lvimr_pkg::lvimr_fast_t fast_src_in,         // Fast source levels
   input  wire lvimr_pkg::lvimr_norm_t norm_src_in,         // Normal source levels
   input  wire logic                mask_wr_in,             // Mask write strobe
   input  wire lvimr_pkg::lvimr_fast_t fast_mask_in,        // Fast mask value
   input  wire lvimr_pkg::lvimr_norm_t norm_mask_in,        // Normal mask value
   output logic                     fast_interrupt_request_out,   // Fast request
   output logic                     normal_interrupt_request_out, // Normal request
   output lvimr_pkg::lvimr_fast_t   fast_status_out,        // Active unmasked fast
   output lvimr_pkg::lvimr_norm_t   norm_status_out,        // Active unmasked normal
   output lvimr_pkg::lvimr_fast_t   fast_mask_out,          // Mask readback
   output lvimr_pkg::lvimr_norm_t   norm_mask_out,          // Mask readback
   output logic [1:0]               cause_out               // Which output leads
);
   logic [`LVIMR_NUM_SRC-1:0] src_sync;   // Synchronised sources
   logic [2:0]                rst_sync;   // Synchronised reset pins
   lvimr_fast_t fast_sync;                // Fast group levels
   lvimr_norm_t norm_sync;                // Normal group levels
   lvimr_fast_t fast_mask_ff;             // Fast mask bits
   lvimr_fast_t nxt_fast_mask;
   lvimr_norm_t norm_mask_ff;             // Normal mask bits
   lvimr_norm_t nxt_norm_mask;
   logic        any_sys_rst;              // Any reset cause active
   lvimr_fast_t nxt_fast_stat;            // Gated fast sources
   lvimr_norm_t nxt_norm_stat;            // Gated normal sources
   logic        nxt_fiq;
   logic        nxt_irq;
   lvimr_sel_t  nxt_sel;                  // Leading output

   // Reduce a gated vector to a request level
   function automatic logic lvimr_any(input logic [`LVIMR_NUM_NORM-1:0] v);
      return |v;
   endfunction

   // Pins cross into the clock domain
   lvimr_sync #(.WIDTH(`LVIMR_NUM_SRC + 3)) u_sync (
      .clock_in (clock_in),
      .rstn_in  (rstn_in),
      .async_in ({power_on_reset_n_in, power_fail_reset_n_in, user_reset_n_in,
                  norm_src_in, fast_src_in}),
      .sync_out ({rst_sync, src_sync})
   );

   // Split sources into the two groups
   assign fast_sync = src_sync[`LVIMR_NUM_FAST-1:0];
   assign norm_sync = src_sync[`LVIMR_NUM_SRC-1:`LVIMR_NUM_FAST];
   // Power-on, power-fail and user reset all act alike here
   assign any_sys_rst = !rstn_in || (rst_sync != `LVIMR_PINS_IDLE);

   // Mask next values
   always_comb begin
      nxt_fast_mask = fast_mask_ff;
      nxt_norm_mask = norm_mask_ff;
      if (any_sys_rst) begin
         nxt_fast_mask = `LVIMR_FAST_RST;
         nxt_norm_mask = `LVIMR_NORM_RST;
      end else if (mask_wr_in) begin
         nxt_fast_mask = fast_mask_in;      // Software enables sources
         nxt_norm_mask = norm_mask_in;
      end
   end

   // Gating, request and precedence next values
   always_comb begin
      nxt_fast_stat = fast_sync & fast_mask_ff;
      nxt_norm_stat = norm_sync & norm_mask_ff;
      nxt_fiq = lvimr_any({`LVIMR_FAST_PAD, nxt_fast_stat});
      nxt_irq = lvimr_any(nxt_norm_stat);
      // Fast wins when both pending; no order inside a group
      if (nxt_fiq) begin
         nxt_sel = LVIMR_SEL_FAST;
      end else if (nxt_irq) begin
         nxt_sel = LVIMR_SEL_NORM;
      end else begin
         nxt_sel = LVIMR_SEL_NONE;
      end
      if (any_sys_rst) begin
         nxt_fast_stat = '0;
         nxt_norm_stat = '0;
         nxt_fiq = 1'b0;
         nxt_irq = 1'b0;
         nxt_sel = LVIMR_SEL_NONE;
      end
   end

   // Register masks and outputs
   always_ff @(posedge clock_in) begin
      fast_mask_ff                 <= nxt_fast_mask;
      norm_mask_ff                 <= nxt_norm_mask;
      fast_mask_out                <= nxt_fast_mask;
      norm_mask_out                <= nxt_norm_mask;
      fast_interrupt_request_out   <= nxt_fiq;
      normal_interrupt_request_out <= nxt_irq;
      fast_status_out              <= nxt_fast_stat;
      norm_status_out              <= nxt_norm_stat;
      cause_out                    <= nxt_sel;
   end
endmodule // lvimr_router

// ==== logic/lvimr_sync.sv ====
`timescale 1ns/1ns
// Two-flop synchroniser for a vector of pin levels
module lvimr_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock_in,   // System clock
   input  wire logic             rstn_in,    // Synchronous reset, active low
   input  wire logic [WIDTH-1:0] async_in,   // Pin levels
   output logic      [WIDTH-1:0] sync_out    // Levels in clock domain
);
   logic [WIDTH-1:0] meta_ff;      // First stage, read only by second
   logic [WIDTH-1:0] nxt_meta;     // Next first stage
   logic [WIDTH-1:0] nxt_sync;     // Next second stage

   // Next values of both stages
   always_comb begin
      nxt_meta = async_in;
      nxt_sync = meta_ff;
      if (!rstn_in) begin
         nxt_meta = '0;
         nxt_sync = '0;
      end
   end

   // Register both stages
   always_ff @(posedge clock_in) begin
      meta_ff  <= nxt_meta;
      sync_out <= nxt_sync;
   end
endmodule // lvimr_sync

// ==== shared/lvimr_defs.svh ====
`ifndef LVIMR_DEFS_SVH
`define LVIMR_DEFS_SVH

// Source counts
`define LVIMR_NUM_SRC      28
`define LVIMR_NUM_FAST     4
`define LVIMR_NUM_NORM     24
// Mask bits after reset
`define LVIMR_FAST_RST     4'h0
`define LVIMR_NORM_RST     24'h000000
// Cause codes shown on the status view
`define LVIMR_CAUSE_NONE   2'h0
`define LVIMR_CAUSE_FAST   2'h1
`define LVIMR_CAUSE_NORM   2'h2
// All three reset pins released (high)
`define LVIMR_PINS_IDLE    3'h7
// Zero padding that widens the fast group to the normal width
`define LVIMR_FAST_PAD     20'h00000

`endif

// ==== shared/lvimr_pkg.sv ====
package lvimr_pkg;
   // Which output currently has precedence
   typedef enum logic [1:0] {
      LVIMR_SEL_NONE,
      LVIMR_SEL_FAST,
      LVIMR_SEL_NORM
   } lvimr_sel_t;
   typedef logic [3:0]  lvimr_fast_t;   // Fast source vector
   typedef logic [23:0] lvimr_norm_t;   // Normal source vector
endpackage
